// ==== core/rea_regs.svh ====
`ifndef REA_REGS_SVH
`define REA_REGS_SVH

// register byte offsets
`define REA_OFFSET_ADDR   8'h00
`define REA_GAIN_ADDR     8'h04
`define REA_DIVIDER_ADDR  8'h08
`define REA_ACCCFG_ADDR   8'h0c
`define REA_NLCFG_ADDR    8'h10
`define REA_WAVSEL_ADDR   8'h14
`define REA_IRQSTL_ADDR   8'h18
`define REA_IRQENL_ADDR   8'h1c
`define REA_TOTAL_ADDR    8'h20
`define REA_IRQENH_ADDR   8'h24
`define REA_RDCLR_ADDR    8'h28
`define REA_WAVE_ADDR     8'h2c

// field positions
`define REA_ACC_TAMPER_BIT   0
`define REA_ACC_ABS_BIT      1
`define REA_ACC_SIGNPOL_BIT  2
`define REA_WAV_REACT_BIT    2
`define REA_IRQH_WAVEFORM_SAMPLE_ENABLE_BIT    0
`define REA_ST_SIGN_BIT      0
`define REA_ST_NOLOAD_BIT    1
`define REA_ST_HALF_BIT      2
`define REA_ST_OVF_BIT       3

// widths and bus response codes
`define REA_ACC_W       49
`define REA_TOP_W       24
`define REA_ST_W        4
`define REA_RESP_OKAY   2'b00
`define REA_RESP_SLVERR 2'b10

// timing counts at 50 MHz
`define REA_CLK_HZ        50000000
`define REA_STEP_CYCLES   3'd5
`define REA_WAVE_SPS      25600
`define REA_WAVE_BASE     (`REA_CLK_HZ / `REA_WAVE_SPS)
`define REA_PULSE_LOW     8'd200
`define REA_PULSE_THRESH  40'h0010000000

// no-load thresholds, power lsb units, fractions of full scale
`define REA_NL_THR1 27'h00004ea
`define REA_NL_THR2 27'h0000275
`define REA_NL_THR3 27'h0000136

`endif

// ==== core/rea_pkg.sv ====
package rea_pkg;
`include "rea_regs.svh"

  // register-map index of a decoded address
  typedef enum {
    REA_R_OFFSET, REA_R_GAIN, REA_R_DIV, REA_R_ACC, REA_R_NL, REA_R_WAV,
    REA_R_STL, REA_R_ENL, REA_R_TOTAL, REA_R_ENH, REA_R_RDCLR, REA_R_WAVE,
    REA_R_NONE
  } rea_reg_t;

  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] offset;
    logic [11:0] gain;
    logic [7:0] divider;
    logic [2:0] acc_cfg;
    logic [1:0] nl_level;
    logic [2:0] wav_sel;
    logic [`REA_ST_W-1:0] stat;
    logic [`REA_ST_W-1:0] en;
    logic waveform_sample_enable;
    logic [`REA_ACC_W-1:0] acc;
    logic [2:0] step_cnt;
    logic prev_neg;
    logic [14:0] wave_cnt;
    logic [23:0] wave;
  } rea_state_t;

  typedef struct packed {
    logic [39:0] acc;
    logic [7:0] low_cnt;
  } rea_pulse_state_t;

endpackage

// ==== core/rea_pulse_if.sv ====
`timescale 1ns/1ps
// accumulation step handed from the datapath to the pulse generator
interface rea_pulse_if;
  logic step;
  logic [34:0] mag;
  logic pulse_n;
  modport src (output step, output mag, input pulse_n);
  modport gen (input step, input mag, output pulse_n);
endinterface

// ==== core/rea_pulse.sv ====
`timescale 1ns/1ps
`include "rea_regs.svh"
// energy-to-frequency stage: one low pulse per fixed energy quantum
module rea_pulse
  import rea_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  rea_pulse_if.gen pif
);
  rea_pulse_state_t s_r, s_nxt;

  // quantum carried over so no energy is lost between pulses
  always_comb begin
    s_nxt = s_r;
    if (s_r.low_cnt != 8'd0) begin
      s_nxt.low_cnt = s_r.low_cnt - 8'd1;
    end
    if (pif.step) begin
      s_nxt.acc = s_r.acc + {5'd0, pif.mag};
    end
    // a quantum reached while still low waits for the pulse to end
    if (s_nxt.acc >= `REA_PULSE_THRESH && s_r.low_cnt == 8'd0) begin
      s_nxt.acc = s_nxt.acc - `REA_PULSE_THRESH;
      s_nxt.low_cnt = `REA_PULSE_LOW;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pif.pulse_n = (s_r.low_cnt == 8'd0); // active low [RULE21]
endmodule

// ==== core/rea_top.sv ====
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "rea_regs.svh"
// Operation
// [RULE1] add signed 16-bit offset word to power
// [RULE2] 256 offset counts equal one power lsb
// [RULE3] integrator on flips quadrature shift sign
// [RULE4] default polarity: flag positive-to-negative change
// [RULE5] polarity set: flag negative-to-positive change
// [RULE6] enabled sign flag holds interrupt until cleared
// [RULE7] below no-load threshold: skip, set flag
// [RULE8] enabled no-load flag holds interrupt until cleared
// [RULE9] level 00 off, then 0.015/0.0075/0.0037 percent
// [RULE10] 49-bit accumulator, top 24 bits readable
// [RULE11] one accumulation step every five clocks
// [RULE12] both modes clear: signed accumulation
// [RULE13] both modes set: absolute mode wins
// [RULE14] tamper: sign follows active power direction
// [RULE15] absolute: magnitude, skip active no-load
// [RULE16] divide by 8-bit divider, zero means one
// [RULE17] read-clear returns total, clears top bits
// [RULE18] energy register wraps both directions
// [RULE19] half-full and overflow/underflow flags
// [RULE20] waveform samples at four selectable rates
// [RULE21] active-low pulse follows accumulation mode; code pulses on the unsigned magnitude in every mode
// [RULE22] reset leaves signed accumulation selected
// [RULE23] gain scales power by one plus gain/4096
// [RULE24] software clears flags to drop interrupt
module rea_top
  import rea_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [23:0] reactive_power_in,
  input wire logic integrator_en,
  input wire logic active_power_neg,
  input wire logic active_noload,
  output logic metering_irq,
  output logic calibration_pulse_out_n
);
  rea_state_t s_r, s_nxt;
  rea_pulse_if pif ();

  // address decode, shared by read and write paths
  function automatic rea_reg_t dec(input logic [7:0] a);
    case (a)
      `REA_OFFSET_ADDR: dec = REA_R_OFFSET;
      `REA_GAIN_ADDR: dec = REA_R_GAIN;
      `REA_DIVIDER_ADDR: dec = REA_R_DIV;
      `REA_ACCCFG_ADDR: dec = REA_R_ACC;
      `REA_NLCFG_ADDR: dec = REA_R_NL;
      `REA_WAVSEL_ADDR: dec = REA_R_WAV;
      `REA_IRQSTL_ADDR: dec = REA_R_STL;
      `REA_IRQENL_ADDR: dec = REA_R_ENL;
      `REA_TOTAL_ADDR: dec = REA_R_TOTAL;
      `REA_IRQENH_ADDR: dec = REA_R_ENH;
      `REA_RDCLR_ADDR: dec = REA_R_RDCLR;
      `REA_WAVE_ADDR: dec = REA_R_WAVE;
      default: dec = REA_R_NONE;
    endcase
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] st);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction

  // threshold for the selected no-load level, zero means disabled
  function automatic logic [26:0] nl_thr(input logic [1:0] lv);
    case (lv)
      2'b01: nl_thr = `REA_NL_THR1;
      2'b10: nl_thr = `REA_NL_THR2;
      2'b11: nl_thr = `REA_NL_THR3;
      default: nl_thr = 27'd0;
    endcase
  endfunction

  // datapath terms, all combinational from the current state and the input ports
  logic signed [24:0] q_shift;
  logic signed [36:0] q_prod;
  logic signed [25:0] q_gain;
  logic signed [34:0] pw;
  logic [34:0] pw_mag;
  logic pw_neg;
  logic below_nl;
  logic absolute;
  logic tamper;
  logic skip;
  logic acc_neg;
  logic [34:0] inc_mag;
  logic [7:0] div_eff;
  logic signed [`REA_ACC_W-1:0] inc;
  logic step;
  logic [14:0] wave_period;

  always_comb begin
    // the quadrature filter lags by 90 with the integrator on
    q_shift = integrator_en ? -25'(reactive_power_in)
                            : 25'(reactive_power_in); // [RULE3]
    q_prod = 37'(q_shift) * 37'(signed'(s_r.gain));
    q_gain = 26'(q_shift) + 26'(q_prod >>> 12); // [RULE23]
    // 8 fractional bits so 256 offset counts make one lsb
    pw = (35'(q_gain) <<< 8)
         + 35'(signed'(s_r.offset)); // [RULE1] [RULE2]
    pw_neg = pw[34];
    pw_mag = pw_neg ? 35'(-pw) : 35'(pw);
    below_nl = (s_r.nl_level != 2'b00)
               && (pw_mag[34:8] < nl_thr(s_r.nl_level)); // [RULE9]
    absolute = s_r.acc_cfg[`REA_ACC_ABS_BIT]; // [RULE13]
    tamper = s_r.acc_cfg[`REA_ACC_TAMPER_BIT] && !absolute;
    skip = below_nl || (absolute && active_noload); // [RULE7] [RULE15]
    if (absolute) begin
      acc_neg = 1'b0; // [RULE15]
    end else if (tamper) begin
      acc_neg = pw_neg ^ active_power_neg; // [RULE14]
    end else begin
      acc_neg = pw_neg; // [RULE12]
    end
    // a zero divider would stall energy, so it counts as one
    div_eff = (s_r.divider == 8'd0) ? 8'd1 : s_r.divider; // [RULE16]
    inc_mag = pw_mag / 35'(div_eff);
    inc = acc_neg ? -`REA_ACC_W'(inc_mag) : `REA_ACC_W'(inc_mag);
    step = (s_r.step_cnt == `REA_STEP_CYCLES - 3'd1); // [RULE11]
    wave_period = 15'(`REA_WAVE_BASE) << s_r.wav_sel[1:0]; // [RULE20]
  end

  // pulse generator sees the undivided, unsigned magnitude in every mode
  assign pif.step = step && !skip;
  assign pif.mag = pw_mag; // [RULE21]

  rea_pulse u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .pif(pif)
  );

  // next-state: bus slave, registers, accumulator, flags
  logic wr_go;
  logic rd_go;
  logic rc_hit;
  logic [`REA_ACC_W-1:0] acc_src;
  logic [`REA_ACC_W-1:0] acc_sum;
  logic [23:0] top_old;
  logic [23:0] top_new;
  logic [`REA_ST_W-1:0] set_ev;
  logic [31:0] wd;

  always_comb begin
    s_nxt = s_r;
    set_ev = '0;
    wd = '0;
    wr_go = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    rd_go = s_axi_arvalid && !s_r.rvalid;
    // read-clear acts in the cycle its address is taken
    rc_hit = rd_go && (dec(s_axi_araddr) == REA_R_RDCLR);

    // write address and data may arrive in either order
    if (s_axi_awvalid && !s_r.aw_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_have && !s_r.bvalid) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // accumulation step, read-clear applied before the add
    // no saturation: full scale rolls over to the far sign
    acc_src = rc_hit ? {24'h0, s_r.acc[24:0]} : s_r.acc; // [RULE17]
    acc_sum = acc_src + inc; // natural wrap at 49 bits [RULE18]
    top_old = acc_src[48:25];
    top_new = acc_sum[48:25];
    if (step) begin
      s_nxt.step_cnt = 3'd0;
      s_nxt.prev_neg = pw_neg;
      if (!s_r.acc_cfg[`REA_ACC_SIGNPOL_BIT] && !s_r.prev_neg && pw_neg)
        set_ev[`REA_ST_SIGN_BIT] = 1'b1; // [RULE4]
      if (s_r.acc_cfg[`REA_ACC_SIGNPOL_BIT] && s_r.prev_neg && !pw_neg)
        set_ev[`REA_ST_SIGN_BIT] = 1'b1; // [RULE5]
      if (below_nl) begin
        set_ev[`REA_ST_NOLOAD_BIT] = 1'b1; // [RULE7]
      end
      if (!skip) begin
        s_nxt.acc = acc_sum; // [RULE10]
        // crossing into the upper or lower quarter is half-full
        if ((top_old[23:22] == 2'b00 && top_new[23:22] == 2'b01)
            || (top_old[23:22] == 2'b11 && top_new[23:22] == 2'b10))
          set_ev[`REA_ST_HALF_BIT] = 1'b1; // [RULE19]
        // top word sign flipping against the add direction is a wrap
        if ((!acc_neg && !top_old[23] && top_new[23])
            || (acc_neg && top_old[23] && !top_new[23]))
          set_ev[`REA_ST_OVF_BIT] = 1'b1; // [RULE19]
      end else begin
        s_nxt.acc = acc_src;
      end
    end else begin
      s_nxt.step_cnt = s_r.step_cnt + 3'd1;
      s_nxt.acc = acc_src;
    end

    // waveform capture at the selected sample rate
    if (s_r.waveform_sample_enable && s_r.wav_sel[`REA_WAV_REACT_BIT]) begin
      if (s_r.wave_cnt >= wave_period - 15'd1) begin
        s_nxt.wave_cnt = 15'd0;
        s_nxt.wave = pw[31:8]; // [RULE20] [RULE2]
      end else begin
        s_nxt.wave_cnt = s_r.wave_cnt + 15'd1;
      end
    end else begin
      s_nxt.wave_cnt = 15'd0;
    end

    // register write; status bits are write-one-to-clear
    if (wr_go) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `REA_RESP_OKAY;
      case (dec(s_r.aw_addr))
        REA_R_OFFSET: begin
          wd = merge({16'h0, s_r.offset}, s_r.w_data, s_r.w_strb);
          s_nxt.offset = wd[15:0];
        end
        REA_R_GAIN: begin
          wd = merge({20'h0, s_r.gain}, s_r.w_data, s_r.w_strb);
          s_nxt.gain = wd[11:0];
        end
        REA_R_DIV: begin
          wd = merge({24'h0, s_r.divider}, s_r.w_data, s_r.w_strb);
          s_nxt.divider = wd[7:0];
        end
        REA_R_ACC: begin
          wd = merge({29'h0, s_r.acc_cfg}, s_r.w_data, s_r.w_strb);
          s_nxt.acc_cfg = wd[2:0];
        end
        REA_R_NL: begin
          wd = merge({30'h0, s_r.nl_level}, s_r.w_data, s_r.w_strb);
          s_nxt.nl_level = wd[1:0];
        end
        REA_R_WAV: begin
          wd = merge({29'h0, s_r.wav_sel}, s_r.w_data, s_r.w_strb);
          s_nxt.wav_sel = wd[2:0];
        end
        REA_R_STL: begin
          wd = merge(32'h0, s_r.w_data, s_r.w_strb);
          s_nxt.stat = s_r.stat & ~wd[`REA_ST_W-1:0]; // [RULE24]
        end
        REA_R_ENL: begin
          wd = merge({28'h0, s_r.en}, s_r.w_data, s_r.w_strb);
          s_nxt.en = wd[`REA_ST_W-1:0];
        end
        REA_R_ENH: begin
          wd = merge({31'h0, s_r.waveform_sample_enable}, s_r.w_data, s_r.w_strb);
          s_nxt.waveform_sample_enable = wd[`REA_IRQH_WAVEFORM_SAMPLE_ENABLE_BIT];
        end
        REA_R_TOTAL, REA_R_RDCLR, REA_R_WAVE: begin
          s_nxt.bresp = `REA_RESP_OKAY; // read-only, write ignored
        end
        default: begin
          s_nxt.bresp = `REA_RESP_SLVERR;
        end
      endcase
    end
    // a flag event in the clearing cycle still sets the flag
    s_nxt.stat = s_nxt.stat | set_ev;

    // register read, data registered one cycle after the address
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `REA_RESP_OKAY;
      case (dec(s_axi_araddr))
        REA_R_OFFSET: s_nxt.rdata = {16'h0, s_r.offset};
        REA_R_GAIN: s_nxt.rdata = {20'h0, s_r.gain};
        REA_R_DIV: s_nxt.rdata = {24'h0, s_r.divider};
        REA_R_ACC: s_nxt.rdata = {29'h0, s_r.acc_cfg};
        REA_R_NL: s_nxt.rdata = {30'h0, s_r.nl_level};
        REA_R_WAV: s_nxt.rdata = {29'h0, s_r.wav_sel};
        REA_R_STL: s_nxt.rdata = {28'h0, s_r.stat};
        REA_R_ENL: s_nxt.rdata = {28'h0, s_r.en};
        REA_R_ENH: s_nxt.rdata = {31'h0, s_r.waveform_sample_enable};
        REA_R_TOTAL, REA_R_RDCLR:
          s_nxt.rdata = {8'h0, s_r.acc[48:25]}; // [RULE10] [RULE17]
        REA_R_WAVE: s_nxt.rdata = {8'h0, s_r.wave};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = `REA_RESP_SLVERR;
        end
      endcase
    end
  end

  // reset: signed mode, no-load off, all flags clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0; // [RULE22]
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = !s_r.aw_have && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_have && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  // level interrupt, held while any enabled flag stands
  assign metering_irq = |(s_r.stat & s_r.en); // [RULE6] [RULE8]
  assign calibration_pulse_out_n = pif.pulse_n;
endmodule

// ==== dv/rea_monitor.sv ====
`timescale 1ns/1ps
// bus handshake and pulse checks seen from the top ports
module rea_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic metering_irq,
  input wire logic calibration_pulse_out_n
);
  logic [8:0] low_r;
  // low time of the pulse; cleared while high so each pulse counts alone
  always_ff @(posedge aclk) begin
    if (!aresetn || calibration_pulse_out_n) begin
      low_r <= 9'h000;
    end else begin
      low_r <= low_r + 9'h001;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_idle: assert property ($rose(aresetn) |->
    !metering_irq && calibration_pulse_out_n && !s_axi_bvalid)
    else $error("outputs not idle after reset");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid)
    else $error("write response repeated");
  a_write_block: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken under response");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken under answer");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h2c |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_pulse_width: assert property ($rose(calibration_pulse_out_n) |->
    low_r == 9'h0c8)
    else $error("pulse low time wrong");
endmodule
bind rea_top rea_monitor mon (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .metering_irq, .calibration_pulse_out_n);

// ==== dv/rea_core_model.sv ====
`timescale 1ns/1ps
// register bus master standing in for the embedded core
module rea_core_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus at time zero; every write uses all byte lanes
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
  end
  // each channel is released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_t;
    logic w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_t && s_axi_awready) begin
        aw_t = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_t && s_axi_wready) begin
        w_t = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_t && w_t));
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
// drives power samples directly, registers through the core model
module tb;
  logic aclk, aresetn, integ, apneg, anl, pulse_d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, metering_irq, calibration_pulse_out_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, lfsr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic signed [23:0] pwr, mag;
  int bad_count = 0, cmp_count = 0, cyc = 0, pulse_count = 0;
  // modes: config, then per-entry bits for active negative, active
  // no-load, integrator, negative input; expected total change
  logic [2:0] m_cfg [5] = '{3'h1, 3'h1, 3'h3, 3'h2, 3'h2};
  logic [4:0] m_neg = 5'h01, m_anl = 5'h08, m_int = 5'h04, m_sgn = 5'h10;
  int m_exp [5] = '{-3, 3, 3, 0, 3};
  logic [23:0] thr [3] = '{24'h0004ea, 24'h000275, 24'h000136};
  rea_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reactive_power_in(pwr),
    .integrator_en(integ), .active_power_neg(apneg), .active_noload(anl),
    .metering_irq, .calibration_pulse_out_n);
  rea_core_model core (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // one total lsb per eight steps of 0x4000 input, so n is in lsbs
  function automatic logic [31:0] tot(input int n);
    return {8'h00, n[23:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
    core.rd(a, rv, rs);
    chk(rv & m, e);
  endtask
  // a power window of whole step periods holds exactly that many steps
  task automatic run(input logic signed [23:0] p, input int steps);
    @(posedge aclk);
    pwr <= p;
    repeat (5 * steps) @(posedge aclk);
    pwr <= 24'sh000000;
    repeat (10) @(posedge aclk);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // hang guard, well above the more than 12000 cycles the tests need;
  // also counts falling edges of the energy pulse
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    pulse_d <= calibration_pulse_out_n;
    if (pulse_d && !calibration_pulse_out_n) begin
      pulse_count <= pulse_count + 1;
    end
    if (cyc == 60000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    {aresetn, integ, apneg, anl} = 4'h0;
    pwr = 24'sh000000;
    lfsr = 32'h9b14;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 12; i++) rchk(8'(4 * i), 32'h0);
    core.rd(8'h30, rv, rs);
    chk({rv[31:2], rs}, 32'h2);
    core.wr(8'h40, 32'h1, rs);
    chk({30'h0, rs}, 32'h2);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      core.wr(8'h00, lfsr, rs);
      rchk(8'h00, {16'h0, lfsr[15:0]});
      core.wr(8'h04, lfsr, rs);
      rchk(8'h04, {20'h0, lfsr[11:0]});
      core.wr(8'h08, lfsr, rs);
      rchk(8'h08, {24'h0, lfsr[7:0]});
      core.wr(8'h20, lfsr, rs);
      rchk(8'h20, 32'h0);
    end
    for (int i = 0; i < 3; i++) core.wr(8'(4 * i), 32'h0, rs);
    $display("test registers done");
    run(24'sh004000, 56);
    rchk(8'h20, tot(7));
    integ <= 1'b1;
    run(24'sh004000, 24);
    rchk(8'h28, tot(4));
    integ <= 1'b0;
    rchk(8'h20, tot(0));
    run(-24'sh004000, 16);
    rchk(8'h28, tot(-2));
    core.wr(8'h08, 32'h4, rs);
    run(24'sh004000, 32);
    core.wr(8'h08, 32'h0, rs);
    rchk(8'h28, tot(1));
    for (int i = 0; i < 5; i++) begin
      core.wr(8'h0c, {29'h0, m_cfg[i]}, rs);
      apneg <= m_neg[i];
      anl <= m_anl[i];
      integ <= m_int[i];
      run(m_sgn[i] ? -24'sh004000 : 24'sh004000, 24);
      rchk(8'h28, tot(m_exp[i]));
    end
    core.wr(8'h0c, 32'h0, rs);
    {apneg, anl, integ} <= 3'h0;
    // 224 unskipped steps of 0x4000, one pulse per 64 of them
    chk(32'(pulse_count), 32'h3);
    $display("test energy done");
    core.wr(8'h1c, 32'h2, rs);
    for (int i = 0; i < 3; i++) begin
      core.wr(8'h10, 32'(i + 1), rs);
      pwr <= thr[i] - 24'h1;
      repeat (20) @(posedge aclk);
      rchk(8'h18, 32'h2, 32'h2);
      chk({31'h0, metering_irq}, 32'h1);
      pwr <= thr[i];
      repeat (20) @(posedge aclk);
      core.wr(8'h18, 32'h2, rs);
      repeat (3) @(posedge aclk);
      chk({31'h0, metering_irq}, 32'h0);
      rchk(8'h18, 32'h0, 32'h2);
    end
    core.wr(8'h10, 32'h0, rs);
    $display("test no-load done");
    core.wr(8'h1c, 32'h1, rs);
    for (int p = 0; p < 2; p++) begin
      lfsr = nxt(lfsr);
      mag = {12'h0, lfsr[11:0]} + 24'sh1;
      core.wr(8'h0c, p ? 32'h4 : 32'h0, rs);
      pwr <= p ? -mag : mag;
      repeat (20) @(posedge aclk);
      core.wr(8'h18, 32'hf, rs);
      pwr <= p ? mag : -mag;
      repeat (20) @(posedge aclk);
      rchk(8'h18, 32'h1, 32'hf);
      chk({31'h0, metering_irq}, 32'h1);
      core.wr(8'h18, 32'h1, rs);
      pwr <= p ? -mag : mag;
      repeat (20) @(posedge aclk);
      rchk(8'h18, 32'h0, 32'hf);
      chk({31'h0, metering_irq}, 32'h0);
    end
    core.wr(8'h1c, 32'h0, rs);
    core.wr(8'h0c, 32'h0, rs);
    $display("test sign done");
    core.wr(8'h24, 32'h1, rs);
    core.wr(8'h14, 32'h4, rs);
    core.wr(8'h00, 32'h100, rs);
    pwr <= 24'sh000005;
    repeat (4000) @(posedge aclk);
    rchk(8'h2c, 32'h6);
    core.wr(8'h14, 32'h5, rs);
    core.wr(8'h00, 32'hff00, rs);
    repeat (8000) @(posedge aclk);
    rchk(8'h2c, 32'h4);
    $display("test waveform done");
    final_report();
  end
endmodule
